// ==== dv/dfpc_fan_model.sv ====
// cooling fan model: measures high time and period of one drive pin
`timescale 1ns/100ps
`default_nettype none
module dfpc_fan_model (
    input wire logic clk_i,
    input wire logic pin_i,
    output int high_o,
    output int period_o
);
    int hc = 0;
    int pc = 0;
    logic last = 1'b0;
    // one full period is latched at each rising edge of the pin
    always @(posedge clk_i) begin
        last <= pin_i;
        if (pin_i && !last) begin
            high_o <= hc;
            period_o <= pc;
            hc <= 1;
            pc <= 1;
        end else begin
            hc <= hc + int'(pin_i);
            pc <= pc + 1;
        end
    end
endmodule : dfpc_fan_model
`default_nettype wire

// ==== dv/dfpc_top_asserts.sv ====
// concurrent checks on the ports of the dual cooling drive controller
`timescale 1ns/100ps
`default_nettype none
module dfpc_top_asserts (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic [11:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    input wire logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    input wire logic AXI_WREADY_O,
    input wire logic [1:0] AXI_BRESP_O,
    input wire logic AXI_BVALID_O,
    input wire logic [11:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    input wire logic AXI_ARREADY_O,
    input wire logic [31:0] AXI_RDATA_O,
    input wire logic [1:0] AXI_RRESP_O,
    input wire logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    input wire logic COOLING_DRIVE_A_O,
    input wire logic COOLING_DRIVE_B_O
);
    logic [9:0] wa;
    logic [7:0] wd;
    logic ws;
    wire aw_hs = AXI_AWVALID_I && AXI_AWREADY_O;
    wire w_hs = AXI_WVALID_I && AXI_WREADY_O;
    wire ar_hs = AXI_ARVALID_I && AXI_ARREADY_O;
    wire to_a = ws && wa == dfpc_pkg::DFPC_IDX_CTRL_A;
    wire to_b = ws && wa == dfpc_pkg::DFPC_IDX_CTRL_B;
    wire wr_map = wa >= dfpc_pkg::DFPC_IDX_CTRL_A && wa <= dfpc_pkg::DFPC_IDX_STATUS;
    wire [9:0] ra = AXI_ARADDR_I[11:2];
    wire ar_map = ra >= dfpc_pkg::DFPC_IDX_CTRL_A && ra <= dfpc_pkg::DFPC_IDX_STATUS;
    // last accepted write address and data
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wa <= 10'h000;
            wd <= 8'h00;
            ws <= 1'b0;
        end else begin
            if (aw_hs) wa <= AXI_AWADDR_I[11:2];
            if (w_hs) wd <= AXI_WDATA_I[7:0];
            if (w_hs) ws <= AXI_WSTRB_I[0];
        end
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_FORCE_A: assert property ($rose(AXI_BVALID_O) && to_a && wd[0]
        |-> ##[1:4] COOLING_DRIVE_A_O [*8]) else $error("drive a not forced high");
    AST_ZERO_A: assert property ($rose(AXI_BVALID_O) && to_a && wd[6:0] == 7'h00
        |-> ##[1:4] !COOLING_DRIVE_A_O [*8]) else $error("drive a not held low");
    AST_FORCE_B: assert property ($rose(AXI_BVALID_O) && to_b && wd[0]
        |-> ##[1:4] COOLING_DRIVE_B_O [*8]) else $error("drive b not forced high");
    AST_WR_TIME: assert property (aw_hs && w_hs
        |=> !AXI_AWREADY_O && !AXI_WREADY_O ##1 AXI_BVALID_O) else $error("write answer late");
    AST_RD_TIME: assert property (ar_hs
        |=> AXI_RVALID_O && !AXI_ARREADY_O) else $error("read answer late");
    AST_R_HOLD: assert property (AXI_RVALID_O && !AXI_RREADY_I
        |=> AXI_RVALID_O && $stable(AXI_RDATA_O)) else $error("read data dropped");
    AST_RD_UNMAP: assert property (ar_hs && !ar_map |=> AXI_RDATA_O == 32'h0
        && AXI_RRESP_O == dfpc_pkg::DFPC_RESP_SLVERR) else $error("unmapped read answer");
    AST_WR_UNMAP: assert property ($rose(AXI_BVALID_O) && !wr_map
        |-> AXI_BRESP_O == dfpc_pkg::DFPC_RESP_SLVERR) else $error("unmapped write answer");
endmodule : dfpc_top_asserts
`default_nettype wire

// ==== dv/dfpc_top_tb.sv ====
// self-checking bench for the dual cooling drive controller
`timescale 1ns/100ps
`default_nettype none
module dfpc_top_tb;
    typedef struct {logic [7:0] a, b, cfg; int hia, pea, hib, peb;} dfpc_row_s;
    localparam int LF = dfpc_pkg::DFPC_SLOT_CYC_3 / 2;
    localparam int LS = dfpc_pkg::DFPC_SLOT_CYC_3;
    localparam logic [11:0] A_CA = {dfpc_pkg::DFPC_IDX_CTRL_A, 2'b00};
    localparam logic [11:0] A_CB = {dfpc_pkg::DFPC_IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_CF = {dfpc_pkg::DFPC_IDX_FAN_CFG, 2'b00};
    localparam logic [11:0] A_ST = {dfpc_pkg::DFPC_IDX_STATUS, 2'b00};
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic arv = 1'b0, rready = 1'b0, awrdy, wrdy, bvalid, arrdy, rvalid, pin_a, pin_b;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [3:0] wstrb = 4'h1;
    logic [31:0] wdata = 32'h00000000, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    int hia, pea, hib, peb;
    int miscompares = 0;
    int checks = 0;
    dfpc_row_s rows [2] = '{'{8'hc0, 8'hfe, 8'h5f, 32 * LF, 64 * LF, 63 * LF, 64 * LF},
        '{8'h82, 8'h0a, 8'h5b, LS, 64 * LS, 5 * LS, 64 * LS}};
    dfpc_top dut_u (.MCLK_I(clk), .RSTN_I(rstn), .AXI_AWADDR_I(awaddr), .AXI_AWPROT_I(3'h0),
        .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awrdy), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
        .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
        .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARPROT_I(3'h0), .AXI_ARVALID_I(arv),
        .AXI_ARREADY_O(arrdy), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
        .AXI_RREADY_I(rready), .COOLING_DRIVE_A_O(pin_a), .COOLING_DRIVE_B_O(pin_b));
    dfpc_fan_model fan_a_u (.clk_i(clk), .pin_i(pin_a), .high_o(hia), .period_o(pea));
    dfpc_fan_model fan_b_u (.clk_i(clk), .pin_i(pin_b), .high_o(hib), .period_o(peb));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (bready && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        if (n >= 100) miscompares++;
        if (n >= 100) stop_test();
    endtask : axw
    // ready is raised a cycle late so the held answer is seen
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (rready && rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (!arv) rready <= 1'b1;
            if (arrdy) arv <= 1'b0;
        end
        if (n >= 100) miscompares++;
        if (n >= 100) stop_test();
    endtask : axr
    initial begin
        repeat (10) @(posedge clk);
        chk("pins in reset", {30'h0, pin_b, pin_a}, 32'h0);
        chk("readies in reset", {29'h0, awrdy, wrdy, arrdy}, 32'h7);
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        axr(A_CA, rd, resp);
        chk("ctrl_a reset", rd, {24'h0, dfpc_pkg::DFPC_CTRL_RST});
        axr(A_CB, rd, resp);
        chk("ctrl_b reset", rd, {24'h0, dfpc_pkg::DFPC_CTRL_RST});
        axr(A_CF, rd, resp);
        chk("fan_cfg reset", rd, {24'h0, dfpc_pkg::DFPC_FAN_CFG_RST});
        foreach (rows[i]) begin
            axw(A_CA, rows[i].a, resp);
            axw(A_CB, rows[i].b, resp);
            axw(A_CF, rows[i].cfg, resp);
            axr(A_CB, rd, resp);
            chk("ctrl_b readback", rd, {24'h0, rows[i].b});
            repeat (2 * rows[i].pea + 100) @(posedge clk);
            chk("high a", hia, rows[i].hia);
            chk("period a", pea, rows[i].pea);
            chk("high b", hib, rows[i].hib);
            chk("period b", peb, rows[i].peb);
        end
        axw(A_CA, 8'h01, resp);
        axw(A_CB, 8'h00, resp);
        repeat (20) @(posedge clk);
        axr(A_ST, rd, resp);
        chk("status a forced", rd, 32'h1);
        axw(A_CA, 8'h00, resp);
        axw(A_CB, 8'h81, resp);
        axw(A_ST, 8'hff, resp);
        chk("status write resp", resp, dfpc_pkg::DFPC_RESP_OKAY);
        repeat (20) @(posedge clk);
        axr(A_ST, rd, resp);
        chk("status b forced", rd, 32'h2);
        axw(12'h400, 8'h55, resp);
        chk("unmapped write resp", resp, dfpc_pkg::DFPC_RESP_SLVERR);
        axr(12'h400, rd, resp);
        chk("unmapped read", {rd[29:0], resp}, {30'h0, dfpc_pkg::DFPC_RESP_SLVERR});
        // low lane strobe off: write answered but nothing stored
        wstrb <= 4'h0;
        axw(A_CA, 8'h55, resp);
        wstrb <= 4'h1;
        chk("strobe off write resp", resp, dfpc_pkg::DFPC_RESP_OKAY);
        axr(A_CA, rd, resp);
        chk("strobe off keeps ctrl_a", rd, 32'h0);
        // reset again in mid-run
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pins in mid reset", {30'h0, pin_b, pin_a}, 32'h0);
        chk("readies in mid reset", {29'h0, awrdy, wrdy, arrdy}, 32'h7);
        rstn <= 1'b1;
        axr(A_CB, rd, resp);
        chk("ctrl_b after mid reset", rd, {24'h0, dfpc_pkg::DFPC_CTRL_RST});
        axr(A_CF, rd, resp);
        chk("fan_cfg after mid reset", rd, {24'h0, dfpc_pkg::DFPC_FAN_CFG_RST});
        stop_test();
    end
endmodule : dfpc_top_tb
bind dfpc_top dfpc_top_asserts chk_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .AXI_AWADDR_I(AXI_AWADDR_I), .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O),
    .AXI_WDATA_I(AXI_WDATA_I), .AXI_WSTRB_I(AXI_WSTRB_I), .AXI_WVALID_I(AXI_WVALID_I),
    .AXI_WREADY_O(AXI_WREADY_O), .AXI_BRESP_O(AXI_BRESP_O), .AXI_BVALID_O(AXI_BVALID_O),
    .AXI_ARADDR_I(AXI_ARADDR_I), .AXI_ARVALID_I(AXI_ARVALID_I), .AXI_ARREADY_O(AXI_ARREADY_O),
    .AXI_RDATA_O(AXI_RDATA_O), .AXI_RRESP_O(AXI_RRESP_O), .AXI_RVALID_O(AXI_RVALID_O),
    .AXI_RREADY_I(AXI_RREADY_I), .COOLING_DRIVE_A_O(COOLING_DRIVE_A_O),
    .COOLING_DRIVE_B_O(COOLING_DRIVE_B_O));
`default_nettype wire

// ==== src/dfpc_pkg.sv ====
// constants shared by the dual cooling drive block
`default_nettype none
package dfpc_pkg;

    // register word indexes; byte address is four times the index
    localparam logic [9:0] DFPC_IDX_CTRL_A = 10'h056;
    localparam logic [9:0] DFPC_IDX_CTRL_B = 10'h057;
    localparam logic [9:0] DFPC_IDX_FAN_CFG = 10'h058;
    localparam logic [9:0] DFPC_IDX_STATUS = 10'h059;

    // reset values
    localparam logic [7:0] DFPC_CTRL_RST = 8'h00;
    localparam logic [7:0] DFPC_FAN_CFG_RST = 8'h50;

    // per-fan control register fields
    localparam int DFPC_FORCE_BIT = 0;
    localparam int DFPC_DUTY_LSB = 1;
    localparam int DFPC_DUTY_W = 6;
    localparam int DFPC_CLKSEL_BIT = 7;

    // fan configuration register fields, fan index added to the base
    localparam int DFPC_SRC_BIT = 0;
    localparam int DFPC_MULT_BIT = 2;

    // axi response codes
    localparam logic [1:0] DFPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DFPC_RESP_SLVERR = 2'h2;

    // timing: one duty slot lasts the chosen time, 64 slots per period
    localparam int DFPC_CLK_NS = 8;
    localparam int DFPC_SLOT_NS_0 = 16000;
    localparam int DFPC_SLOT_NS_1 = 8000;
    localparam int DFPC_SLOT_NS_2 = 4000;
    localparam int DFPC_SLOT_NS_3 = 2000;
    localparam int DFPC_SLOT_CYC_0 = DFPC_SLOT_NS_0 / DFPC_CLK_NS;
    localparam int DFPC_SLOT_CYC_1 = DFPC_SLOT_NS_1 / DFPC_CLK_NS;
    localparam int DFPC_SLOT_CYC_2 = DFPC_SLOT_NS_2 / DFPC_CLK_NS;
    localparam int DFPC_SLOT_CYC_3 = DFPC_SLOT_NS_3 / DFPC_CLK_NS;
    localparam int DFPC_DIV_W = 12;

    typedef enum logic [1:0] {
        DFPC_WR_COLLECT = 2'b00,
        DFPC_WR_RESP = 2'b01
    } dfpc_wr_state_e;

    typedef enum logic [1:0] {
        DFPC_RD_IDLE = 2'b00,
        DFPC_RD_DATA = 2'b01
    } dfpc_rd_state_e;

endpackage : dfpc_pkg
`default_nettype wire

// ==== src/dfpc_slot_gen.sv ====
// one cooling drive: slot divider, 64-slot counter and pin flop
`timescale 1ns/100ps
`default_nettype none
module dfpc_slot_gen (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] ctrl_i,
    input wire logic src_sel_i,
    input wire logic mult_i,
    output logic drive_o
);

    logic [dfpc_pkg::DFPC_DIV_W-1:0] div_cnt;
    logic [dfpc_pkg::DFPC_DUTY_W-1:0] slot;
    logic [dfpc_pkg::DFPC_DIV_W-1:0] base_cyc;
    logic [dfpc_pkg::DFPC_DIV_W-1:0] slot_last;
    logic slot_tick;
    logic force_high;
    logic [dfpc_pkg::DFPC_DUTY_W-1:0] duty;
    logic next_drive;
    logic [1:0] rate_sel;

    assign rate_sel = {src_sel_i, ctrl_i[dfpc_pkg::DFPC_CLKSEL_BIT]}; // RQ6
    assign base_cyc = (rate_sel == 2'h0) ? dfpc_pkg::DFPC_DIV_W'(dfpc_pkg::DFPC_SLOT_CYC_0) :
                      (rate_sel == 2'h1) ? dfpc_pkg::DFPC_DIV_W'(dfpc_pkg::DFPC_SLOT_CYC_1) :
                      (rate_sel == 2'h2) ? dfpc_pkg::DFPC_DIV_W'(dfpc_pkg::DFPC_SLOT_CYC_2) :
                      dfpc_pkg::DFPC_DIV_W'(dfpc_pkg::DFPC_SLOT_CYC_3);
    // halving the slot length doubles the output frequency
    assign slot_last = (mult_i ? (base_cyc >> 1) : base_cyc) - 1'b1; // RQ9
    assign slot_tick = (div_cnt >= slot_last);
    assign force_high = ctrl_i[dfpc_pkg::DFPC_FORCE_BIT];
    assign duty = ctrl_i[dfpc_pkg::DFPC_DUTY_LSB +: dfpc_pkg::DFPC_DUTY_W];
    // high for duty slots of 64; zero gives low, 63 gives 63 high and 1 low
    assign next_drive = force_high | (slot < duty); // RQ1 RQ2 RQ4 RQ5 RQ10

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= '0;
            slot <= '0;
        end else if (slot_tick) begin
            div_cnt <= '0;
            slot <= slot + 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_o <= 1'b0;
        end else begin
            drive_o <= next_drive;
        end
    end

endmodule : dfpc_slot_gen
`default_nettype wire

// ==== src/dfpc_top.sv ====
// dual cooling drive controller with axi4-lite register slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1 - force bit holds drive high
// RQ2 - duty bits 6:1, zero holds low
// RQ3 - second drive has identical own register
// RQ4 - duty 100000 gives half duty
// RQ5 - duty 111111 gives 63 high, 1 low
// RQ6 - bit 7 with config bits picks frequency
// RQ7 - config bit 2 doubles drive A frequency
// RQ8 - config bit 3 doubles drive B frequency
// RQ9 - multiplier 0 none, 1 doubles
// RQ10 - duty N gives N of 64 slots high
module dfpc_top (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic [11:0] AXI_AWADDR_I,
    input wire logic [2:0] AXI_AWPROT_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    output logic [1:0] AXI_BRESP_O,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [11:0] AXI_ARADDR_I,
    input wire logic [2:0] AXI_ARPROT_I,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    output logic COOLING_DRIVE_A_O,
    output logic COOLING_DRIVE_B_O
);

    // register selection for one word address
    typedef struct packed {
        logic ctrl_a;
        logic ctrl_b;
        logic fan_cfg;
        logic status;
    } dfpc_sel_s;

    function automatic dfpc_sel_s dfpc_decode(input logic [11:0] addr);
        dfpc_sel_s sel;
        sel.ctrl_a = (addr[11:2] == dfpc_pkg::DFPC_IDX_CTRL_A);
        sel.ctrl_b = (addr[11:2] == dfpc_pkg::DFPC_IDX_CTRL_B);
        sel.fan_cfg = (addr[11:2] == dfpc_pkg::DFPC_IDX_FAN_CFG);
        sel.status = (addr[11:2] == dfpc_pkg::DFPC_IDX_STATUS);
        return sel;
    endfunction : dfpc_decode

    // register state
    logic [7:0] cooling_ctrl_a;
    logic [7:0] cooling_ctrl_b;
    logic [7:0] fan_cfg;
    logic [1:0] drive;

    // write channel state
    dfpc_pkg::dfpc_wr_state_e wr_state;
    logic aw_held;
    logic w_held;
    logic [11:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;

    // read channel state
    dfpc_pkg::dfpc_rd_state_e rd_state;

    // decode and selection
    dfpc_sel_s wr_sel;
    dfpc_sel_s rd_sel;
    logic aw_take;
    logic w_take;
    logic have_aw;
    logic have_w;
    logic wr_fire;
    logic wr_hit;
    logic wr_apply;
    logic ar_take;
    logic rd_hit;
    logic [7:0] rd_byte;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [1:0] next_bresp;
    logic [7:0] status_byte;
    logic [15:0] ctrl_flat;

    assign aw_take = AXI_AWVALID_I & AXI_AWREADY_O;
    assign w_take = AXI_WVALID_I & AXI_WREADY_O;
    assign have_aw = aw_held | aw_take;
    assign have_w = w_held | w_take;
    // address and data may arrive in either order; commit once both are in
    assign wr_fire = (wr_state == dfpc_pkg::DFPC_WR_COLLECT) & aw_held & w_held;
    assign wr_sel = dfpc_decode(wr_addr);
    assign wr_hit = wr_sel.ctrl_a | wr_sel.ctrl_b | wr_sel.fan_cfg;
    assign wr_apply = wr_fire & wr_lane0;
    assign next_bresp = (wr_hit | wr_sel.status) ? dfpc_pkg::DFPC_RESP_OKAY :
                        dfpc_pkg::DFPC_RESP_SLVERR;

    assign ar_take = AXI_ARVALID_I & AXI_ARREADY_O;
    assign rd_sel = dfpc_decode(AXI_ARADDR_I);
    assign rd_hit = rd_sel.ctrl_a | rd_sel.ctrl_b | rd_sel.fan_cfg | rd_sel.status;
    assign status_byte = {6'h00, drive};
    assign rd_byte = rd_sel.ctrl_a ? cooling_ctrl_a :
                     rd_sel.ctrl_b ? cooling_ctrl_b :
                     rd_sel.fan_cfg ? fan_cfg :
                     rd_sel.status ? status_byte : 8'h00;
    assign next_rdata = {24'h000000, rd_byte};
    assign next_rresp = rd_hit ? dfpc_pkg::DFPC_RESP_OKAY : dfpc_pkg::DFPC_RESP_SLVERR;

    // write address capture
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_addr <= 12'h000;
        end else if (aw_take) begin
            wr_addr <= AXI_AWADDR_I;
        end
    end

    // write data capture, only the low byte lane carries register bits
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_byte <= 8'h00;
            wr_lane0 <= 1'b0;
        end else if (w_take) begin
            wr_byte <= AXI_WDATA_I[7:0];
            wr_lane0 <= AXI_WSTRB_I[0];
        end
    end

    // write channel sequencing
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_state <= dfpc_pkg::DFPC_WR_COLLECT;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            AXI_AWREADY_O <= 1'b1;
            AXI_WREADY_O <= 1'b1;
            AXI_BVALID_O <= 1'b0;
            AXI_BRESP_O <= dfpc_pkg::DFPC_RESP_OKAY;
        end else begin
            case (wr_state)
                dfpc_pkg::DFPC_WR_COLLECT: begin
                    if (wr_fire) begin
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        AXI_BVALID_O <= 1'b1;
                        AXI_BRESP_O <= next_bresp;
                        wr_state <= dfpc_pkg::DFPC_WR_RESP;
                    end else begin
                        aw_held <= have_aw;
                        w_held <= have_w;
                        AXI_AWREADY_O <= ~have_aw;
                        AXI_WREADY_O <= ~have_w;
                    end
                end
                dfpc_pkg::DFPC_WR_RESP: begin
                    if (AXI_BREADY_I) begin
                        AXI_BVALID_O <= 1'b0;
                        AXI_AWREADY_O <= 1'b1;
                        AXI_WREADY_O <= 1'b1;
                        wr_state <= dfpc_pkg::DFPC_WR_COLLECT;
                    end
                end
                default: begin
                    wr_state <= dfpc_pkg::DFPC_WR_COLLECT;
                    aw_held <= 1'b0;
                    w_held <= 1'b0;
                    AXI_AWREADY_O <= 1'b1;
                    AXI_WREADY_O <= 1'b1;
                    AXI_BVALID_O <= 1'b0;
                end
            endcase
        end
    end

    // drive A register
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cooling_ctrl_a <= dfpc_pkg::DFPC_CTRL_RST;
        end else if (wr_apply && wr_sel.ctrl_a) begin
            cooling_ctrl_a <= wr_byte; // RQ1 RQ2
        end
    end

    // drive B register, same layout, kept apart
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cooling_ctrl_b <= dfpc_pkg::DFPC_CTRL_RST;
        end else if (wr_apply && wr_sel.ctrl_b) begin
            cooling_ctrl_b <= wr_byte; // RQ3
        end
    end

    // source select, multipliers and stored tachometer divisors
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fan_cfg <= dfpc_pkg::DFPC_FAN_CFG_RST;
        end else if (wr_apply && wr_sel.fan_cfg) begin
            fan_cfg <= wr_byte; // RQ6 RQ7 RQ8
        end
    end

    // read channel sequencing
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rd_state <= dfpc_pkg::DFPC_RD_IDLE;
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O <= 1'b0;
            AXI_RDATA_O <= 32'h00000000;
            AXI_RRESP_O <= dfpc_pkg::DFPC_RESP_OKAY;
        end else begin
            case (rd_state)
                dfpc_pkg::DFPC_RD_IDLE: begin
                    if (ar_take) begin
                        AXI_ARREADY_O <= 1'b0;
                        AXI_RVALID_O <= 1'b1;
                        AXI_RDATA_O <= next_rdata;
                        AXI_RRESP_O <= next_rresp;
                        rd_state <= dfpc_pkg::DFPC_RD_DATA;
                    end
                end
                dfpc_pkg::DFPC_RD_DATA: begin
                    if (AXI_RREADY_I) begin
                        AXI_RVALID_O <= 1'b0;
                        AXI_ARREADY_O <= 1'b1;
                        rd_state <= dfpc_pkg::DFPC_RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= dfpc_pkg::DFPC_RD_IDLE;
                    AXI_ARREADY_O <= 1'b1;
                    AXI_RVALID_O <= 1'b0;
                end
            endcase
        end
    end

    // both drives share one generator shape
    assign ctrl_flat = {cooling_ctrl_b, cooling_ctrl_a};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_drive
            dfpc_slot_gen u_slot_gen (
                .clk_i(MCLK_I),
                .rst_n_i(RSTN_I),
                .ctrl_i(ctrl_flat[i*8 +: 8]),
                .src_sel_i(fan_cfg[dfpc_pkg::DFPC_SRC_BIT + i]), // RQ6
                .mult_i(fan_cfg[dfpc_pkg::DFPC_MULT_BIT + i]), // RQ7 RQ8 RQ9
                .drive_o(drive[i])
            );
        end
    endgenerate

    assign COOLING_DRIVE_A_O = drive[0];
    assign COOLING_DRIVE_B_O = drive[1];

endmodule : dfpc_top
`default_nettype wire
